// ==== shared/imr_pkg.sv ====
package imr_pkg;

   // ==========================================================
   // register word addresses
   localparam logic [15:0] ADDR_RES = 16'h03fc;
   localparam logic [15:0] ADDR_CAP = 16'h03fe;
   localparam logic [15:0] ADDR_RQUAL = 16'h0402;
   localparam logic [15:0] ADDR_CQUAL = 16'h0403;
   localparam logic [15:0] ADDR_VGND = 16'h0405;
   localparam logic [15:0] ADDR_INJ = 16'h0407;
   localparam logic [15:0] ADDR_ALARM = 16'h044c;
   localparam logic [15:0] ADDR_STAT = 16'h044e;
   localparam logic [15:0] ADDR_STATN = 16'h044f;
   localparam logic [15:0] ADDR_SCNT = 16'h0450;
   localparam logic [15:0] ADDR_UNIT = 16'h0456;
   localparam logic [15:0] ADDR_TEST = 16'h07d0;
   localparam logic [15:0] ADDR_UPTIME = 16'h07d1;
   localparam logic [15:0] ADDR_PCYC = 16'h07d5;

   // ==========================================================
   // readable groups: base word and number of words
   localparam int NGRP = 13;
   localparam logic [15:0] GRP_BASE [NGRP] = '{
      ADDR_RES, ADDR_CAP, ADDR_RQUAL, ADDR_CQUAL, ADDR_VGND, ADDR_INJ,
      ADDR_ALARM, ADDR_STAT, ADDR_STATN, ADDR_SCNT, ADDR_UNIT,
      ADDR_UPTIME, ADDR_PCYC};
   localparam logic [15:0] GRP_WORDS [NGRP] = '{
      16'h0002, 16'h0002, 16'h0001, 16'h0001, 16'h0002, 16'h0002,
      16'h0001, 16'h0001, 16'h0001, 16'h0002, 16'h0002,
      16'h0004, 16'h0002};
   localparam int G_RES = 0;
   localparam int G_CAP = 1;
   localparam int G_RQUAL = 2;
   localparam int G_CQUAL = 3;
   localparam int G_VGND = 4;
   localparam int G_INJ = 5;
   localparam int G_ALARM = 6;
   localparam int G_STAT = 7;
   localparam int G_STATN = 8;
   localparam int G_SCNT = 9;
   localparam int G_UNIT = 10;
   localparam int G_UPTIME = 11;
   localparam int G_PCYC = 12;

   // ==========================================================
   // codes and field positions
   localparam logic [31:0] NAN_PATTERN = 32'hffc00000;
   localparam logic [15:0] RUN_CODE = 16'ha456;
   localparam logic [31:0] INJ_ACTIVE_CODE = 32'h00000000;
   localparam logic [31:0] INJ_INACTIVE_CODE = 32'h00000001;
   localparam int ALARM_BIT_ACTIVE = 0;
   localparam int ALARM_BIT_PREVENT = 1;
   localparam int ALARM_BIT_TRANSIENT = 2;
   localparam int ALARM_BIT_ACKED = 3;
   localparam int STAT_BIT_STATUS = 1;
   localparam int STAT_BIT_SYSERR = 13;
   localparam int STAT_BIT_PRODERR = 14;
   localparam int STAT_BIT_INJOFF = 15;

   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int UPTIME_TICK_NS = 1000000000;
   localparam int UPTIME_TICK_CYCLES = UPTIME_TICK_NS / CLK_PERIOD_NS;

   // ==========================================================
   // types
   typedef enum logic [2:0] {
      QUAL_EQUAL = 3'h0,
      QUAL_UNDER = 3'h1,
      QUAL_OVER = 3'h2,
      QUAL_UNDER_STRICT = 3'h3,
      QUAL_OVER_STRICT = 3'h4
   } imr_qual_type;

   typedef struct packed {
      logic [15:0] addr;
      logic rd;
      logic wr;
      logic [15:0] wdata;
   } imr_req_type;

   typedef struct packed {
      logic [31:0] resistance;
      logic [31:0] capacitance;
      imr_qual_type res_qual;
      imr_qual_type cap_qual;
      logic [31:0] ground_voltage;
      logic [31:0] unit_status;
   } imr_meas_type;

   typedef struct packed {
      logic alarm_active;
      logic prev_alarm_active;
      logic transient_alarm;
      logic alarm_acked;
      logic first_meas;
      logic inj_disconnected;
      logic over_voltage;
      logic over_capacitance;
      logic injection_active;
   } imr_cond_type;

endpackage

// ==== verilog/imr_snap.sv ====
`timescale 1ns/1ps
module imr_snap (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // read access
   input wire logic rd,
   input wire logic [3:0] grp,
   input wire logic [1:0] idx,
   input wire logic [63:0] live,
   // selected word
   output logic [15:0] word
);
   logic [63:0] shadow_reg;
   logic [3:0] shadow_grp_reg;
   logic shadow_ok_reg;
   logic use_shadow;
   logic [63:0] src;

   // later words of a group come from the copy taken at its first word
   assign use_shadow = (idx != 2'h0) && shadow_ok_reg && (shadow_grp_reg == grp);
   assign src = use_shadow ? shadow_reg : live;
   assign word = src[6'd63 - {idx, 4'h0} -: 16];

   always_ff @(posedge clk) begin
      if (reset) begin
         shadow_reg <= 64'h0;
         shadow_grp_reg <= 4'h0;
         shadow_ok_reg <= 1'b0;
      end else if (rd && idx == 2'h0) begin
         shadow_reg <= live;
         shadow_grp_reg <= grp;
         shadow_ok_reg <= 1'b1;
      end
   end
endmodule

// ==== verilog/imr_test.sv ====
`timescale 1ns/1ps
module imr_test (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // command and engine
   input wire logic go,
   input wire logic done,
   input wire logic fail,
   // state
   output logic start_reg,
   output logic busy_reg,
   output logic failed_reg
);
   typedef enum logic {TEST_IDLE, TEST_RUN} imr_test_state_type;
   imr_test_state_type state_reg;

   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg <= TEST_IDLE;
         start_reg <= 1'b0;
         busy_reg <= 1'b0;
         failed_reg <= 1'b0;
      end else begin
         start_reg <= 1'b0;
         unique case (state_reg)
            TEST_IDLE: begin
               // a run code while running is dropped, not queued
               if (go) begin
                  state_reg <= TEST_RUN;
                  start_reg <= 1'b1;
                  busy_reg <= 1'b1;
                  failed_reg <= 1'b0;
               end
            end
            TEST_RUN: begin
               if (done) begin
                  state_reg <= TEST_IDLE;
                  busy_reg <= 1'b0;
                  failed_reg <= fail;
               end
            end
         endcase
      end
   end
endmodule

// ==== verilog/imr_regs.sv ====
`timescale 1ns/1ps
// Overview of operation
// - During self-test the resistance words read as the quiet NaN pattern.
// - During self-test the capacitance words read as NaN where fitted.
// - Qualifier words read 0 equal, 1 under, 2 over, 3/4 strictly.
// - Injection state reads 0 when injection runs and 1 when it does not.
// - Alarm word is 0, or codes 1 active, 2 preventive, 4 transient, 8 ack.
// - Status bit 1 is set on alarm, preventive, ack or first measurement.
// - Status bit 13 is set on injection loss, over voltage or over cap.
// - Status bit 14 is set when the last self-test failed.
// - Status bit 15 is set while injection is disabled.
// - The word after the status word is always its complement.
// - Writing the run code to the command word starts a self-test.
// - Uptime since first power-up is reported over four read-only words.
// - A 32-bit power cycle count rises by one per power-up.
module imr_regs #(
   parameter int TICK_CYCLES = imr_pkg::UPTIME_TICK_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // register port
   input wire imr_pkg::imr_req_type reg_req,
   output logic [15:0] reg_rdata,
   output logic reg_rvalid,
   // measurement core
   input wire imr_pkg::imr_meas_type meas,
   input wire imr_pkg::imr_cond_type cond,
   input wire logic cap_present,
   // self-test engine
   input wire logic selftest_done,
   input wire logic selftest_fail,
   output logic selftest_start,
   output logic selftest_busy,
   // non-volatile history
   input wire logic [63:0] nv_uptime,
   input wire logic [31:0] nv_power_cycles
);
   import imr_pkg::*;

   // ==========================================================
   // declarations
   logic [63:0] grp_val [NGRP];
   logic [NGRP-1:0] grp_hit;
   logic [1:0] grp_idx [NGRP];
   logic [63:0] sel_val;
   logic [3:0] sel_grp;
   logic [1:0] sel_idx;
   logic mapped;
   logic [15:0] rd_word;
   logic [31:0] res_word;
   logic [31:0] cap_word;
   logic [31:0] inj_word;
   logic [15:0] alarm_code;
   logic [15:0] stat_reg;
   logic [15:0] stat_next;
   logic [31:0] scnt_reg;
   logic [63:0] uptime_reg;
   logic [31:0] pcyc_reg;
   logic [31:0] tick_reg;
   logic tick_done;
   logic loaded_reg;
   logic test_go;
   logic test_failed;

   // ==========================================================
   // address decode
   generate
      for (genvar g = 0; g < NGRP; g++) begin : gen_dec
         logic [15:0] off;
         assign off = reg_req.addr - GRP_BASE[g];
         assign grp_hit[g] = off < GRP_WORDS[g];
         assign grp_idx[g] = off[1:0];
      end
   endgenerate

   assign mapped = |grp_hit;

   always_comb begin
      sel_val = 64'h0;
      sel_grp = 4'h0;
      sel_idx = 2'h0;
      for (int g = 0; g < NGRP; g++) begin
         if (grp_hit[g]) begin
            sel_val = sel_val | grp_val[g];
            sel_grp = sel_grp | 4'(g);
            sel_idx = sel_idx | grp_idx[g];
         end
      end
   end

   // ==========================================================
   // live values, left aligned in 64 bits
   assign res_word = selftest_busy ? NAN_PATTERN : meas.resistance;
   assign cap_word = !cap_present ? 32'h0 :
      (selftest_busy ? NAN_PATTERN : meas.capacitance);
   assign inj_word = cond.injection_active ? INJ_ACTIVE_CODE :
      INJ_INACTIVE_CODE;

   always_comb begin
      alarm_code = 16'h0;
      alarm_code[ALARM_BIT_ACTIVE] = cond.alarm_active;
      alarm_code[ALARM_BIT_PREVENT] = cond.prev_alarm_active;
      alarm_code[ALARM_BIT_TRANSIENT] = cond.transient_alarm;
      alarm_code[ALARM_BIT_ACKED] = cond.alarm_acked;
   end

   always_comb begin
      stat_next = 16'h0;
      stat_next[STAT_BIT_STATUS] = cond.alarm_active |
         cond.prev_alarm_active | cond.alarm_acked |
         cond.first_meas;
      stat_next[STAT_BIT_SYSERR] = cond.inj_disconnected |
         cond.over_voltage | cond.over_capacitance;
      stat_next[STAT_BIT_PRODERR] = test_failed;
      stat_next[STAT_BIT_INJOFF] = !cond.injection_active;
   end

   assign grp_val[G_RES] = {res_word, 32'h0};
   assign grp_val[G_CAP] = {cap_word, 32'h0};
   assign grp_val[G_RQUAL] = {13'h0, meas.res_qual, 48'h0};
   assign grp_val[G_CQUAL] = {13'h0, meas.cap_qual, 48'h0};
   assign grp_val[G_VGND] = {meas.ground_voltage, 32'h0};
   assign grp_val[G_INJ] = {inj_word, 32'h0};
   assign grp_val[G_ALARM] = {alarm_code, 48'h0};
   assign grp_val[G_STAT] = {stat_reg, 48'h0};
   assign grp_val[G_STATN] = {~stat_reg, 48'h0};
   assign grp_val[G_SCNT] = {scnt_reg, 32'h0};
   assign grp_val[G_UNIT] = {meas.unit_status, 32'h0};
   assign grp_val[G_UPTIME] = uptime_reg;
   assign grp_val[G_PCYC] = {pcyc_reg, 32'h0};

   // ==========================================================
   // read path with pair snapshot
   imr_snap imr_snap_inst (
      .clk(clk),
      .reset(reset),
      .rd(reg_req.rd && mapped),
      .grp(sel_grp),
      .idx(sel_idx),
      .live(sel_val),
      .word(rd_word)
   );

   // unmapped and write-only words read as zero
   always_ff @(posedge clk) begin
      if (reset) begin
         reg_rdata <= 16'h0;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_req.rd;
         if (reg_req.rd) begin
            reg_rdata <= mapped ? rd_word : 16'h0;
         end
      end
   end

   // ==========================================================
   // self-test command
   assign test_go = reg_req.wr && reg_req.addr == ADDR_TEST &&
      reg_req.wdata == RUN_CODE;

   imr_test imr_test_inst (
      .clk(clk),
      .reset(reset),
      .go(test_go),
      .done(selftest_done),
      .fail(selftest_fail),
      .start_reg(selftest_start),
      .busy_reg(selftest_busy),
      .failed_reg(test_failed)
   );

   // ==========================================================
   // status word and change counter
   always_ff @(posedge clk) begin
      if (reset) begin
         stat_reg <= 16'h0;
         scnt_reg <= 32'h0;
      end else begin
         stat_reg <= stat_next;
         // counter wraps; it only tracks how often the word moved
         if (loaded_reg && stat_next != stat_reg) begin
            scnt_reg <= scnt_reg + 32'h1;
         end
      end
   end

   // ==========================================================
   // uptime and power cycles
   assign tick_done = tick_reg == 32'(TICK_CYCLES - 1);

   // history is taken one cycle after reset, never inside it
   always_ff @(posedge clk) begin
      if (reset) begin
         loaded_reg <= 1'b0;
         uptime_reg <= 64'h0;
         pcyc_reg <= 32'h0;
         tick_reg <= 32'h0;
      end else if (!loaded_reg) begin
         loaded_reg <= 1'b1;
         uptime_reg <= nv_uptime;
         pcyc_reg <= nv_power_cycles + 32'h1;
      end else begin
         tick_reg <= tick_done ? 32'h0 : tick_reg + 32'h1;
         if (tick_done) begin
            uptime_reg <= uptime_reg + 64'h1;
         end
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_res_nan: assert property (
      reg_req.rd && reg_req.addr == ADDR_RES && selftest_busy
      |=> reg_rdata == NAN_PATTERN[31:16])
      else $error("resistance not NaN during self-test");

   a_cap_nan: assert property (
      reg_req.rd && reg_req.addr == ADDR_CAP && selftest_busy && cap_present
      |=> reg_rdata == NAN_PATTERN[31:16])
      else $error("capacitance not NaN during self-test");

   a_qual_code: assert property (
      reg_req.rd && reg_req.addr == ADDR_RQUAL
      |=> reg_rdata == {13'h0, $past(meas.res_qual)})
      else $error("resistance qualifier mismatch");

   a_inj_code: assert property (
      reg_req.rd && reg_req.addr == ADDR_INJ ##1
      reg_req.rd && reg_req.addr == ADDR_INJ + 16'h1
      |=> reg_rdata == {15'h0, !$past(cond.injection_active, 2)})
      else $error("injection state code wrong");

   a_alarm_code: assert property (
      reg_req.rd && reg_req.addr == ADDR_ALARM
      |=> reg_rdata == {12'h0, $past(cond.alarm_acked),
         $past(cond.transient_alarm), $past(cond.prev_alarm_active),
         $past(cond.alarm_active)})
      else $error("alarm code wrong");

   a_stat_status: assert property (
      reg_req.rd && reg_req.addr == ADDR_STAT && $past(!reset)
      |=> reg_rdata[STAT_BIT_STATUS] == $past(cond.alarm_active |
         cond.prev_alarm_active | cond.alarm_acked | cond.first_meas, 2))
      else $error("status bit 1 wrong");

   a_stat_syserr: assert property (
      reg_req.rd && reg_req.addr == ADDR_STAT && $past(!reset)
      |=> reg_rdata[STAT_BIT_SYSERR] == $past(cond.inj_disconnected |
         cond.over_voltage | cond.over_capacitance, 2))
      else $error("system error bit wrong");

   a_stat_failbit: assert property (
      selftest_done && selftest_busy
      |-> ##2 stat_reg[STAT_BIT_PRODERR] == $past(selftest_fail, 2))
      else $error("self-test failure bit wrong");

   a_stat_injoff: assert property (
      reg_req.rd && reg_req.addr == ADDR_STAT && $past(!reset)
      |=> reg_rdata[STAT_BIT_INJOFF] == !$past(cond.injection_active, 2))
      else $error("injection disabled bit wrong");

   a_stat_inverse: assert property (
      reg_req.rd && reg_req.addr == ADDR_STATN
      |=> reg_rdata == ~$past(stat_reg))
      else $error("complement word wrong");

   a_test_start: assert property (
      test_go && !selftest_busy |=> selftest_start ##1 !selftest_start
      && (selftest_busy || $past(selftest_done)))
      else $error("self-test did not start");

   a_uptime_tick: assert property (
      loaded_reg && tick_done |=> uptime_reg == $past(uptime_reg) + 64'h1)
      else $error("uptime did not advance");

   a_pcyc_load: assert property (
      $rose(loaded_reg) |-> pcyc_reg == $past(nv_power_cycles) + 32'h1)
      else $error("power cycle count wrong");

   a_pair_sample: assert property (
      reg_req.rd && reg_req.addr == ADDR_VGND ##1
      reg_req.rd && reg_req.addr == ADDR_VGND + 16'h1
      |=> reg_rdata == $past(meas.ground_voltage[15:0], 2))
      else $error("pair halves from different samples");

   a_test_ignore: assert property (
      reg_req.wr && reg_req.addr == ADDR_TEST &&
      reg_req.wdata != RUN_CODE && !selftest_busy |=> !selftest_start)
      else $error("self-test started by wrong code");

   c_test_run: cover property (selftest_start ##[1:50] selftest_done);
   c_pair_read: cover property (reg_req.rd && reg_req.addr == ADDR_RES
      ##1 reg_req.rd && reg_req.addr == ADDR_RES + 16'h1);
   c_stat_change: cover property (loaded_reg && stat_next != stat_reg);
   c_uptime_tick: cover property (loaded_reg && tick_done);
endmodule

// ==== bench/imr_master.sv ====
`timescale 1ns/1ps
// ==========================================================
// register master: polls and commands the register bank
module imr_master (
   // clock
   input wire logic clk,
   // request
   output imr_pkg::imr_req_type req
);
   import imr_pkg::*;

   initial begin
      req = '0;
   end

   // words of one value go back to back, word 0 first
   task automatic read_words(input logic [15:0] base, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         req.rd <= 1'b1;
         req.addr <= base + 16'(i);
      end
      @(posedge clk);
      req.rd <= 1'b0;
      // released address shows garbage, not the last value
      req.addr <= ~(base + 16'(n - 1));
   endtask

   task automatic write_word(input logic [15:0] addr,
         input logic [15:0] data);
      @(posedge clk);
      req.wr <= 1'b1;
      req.addr <= addr;
      req.wdata <= data;
      @(posedge clk);
      req.wr <= 1'b0;
      req.wdata <= ~data;
      req.addr <= ~addr;
   endtask
endmodule

// ==== bench/imr_regs_tb.sv ====
`timescale 1ns/1ps
module imr_regs_tb;
   import imr_pkg::*;

   localparam int TICK = 4;
   logic clk;
   logic reset;
   imr_req_type reg_req;
   logic [15:0] reg_rdata;
   logic reg_rvalid;
   imr_meas_type meas;
   imr_cond_type cond;
   imr_cond_type cv;
   logic cap_present;
   logic selftest_done;
   logic selftest_fail;
   logic selftest_start;
   logic selftest_busy;
   logic [63:0] nv_uptime;
   logic [31:0] nv_power_cycles;
   int failures;
   int total_checks;
   int seed;
   logic failed_exp;
   logic [31:0] r;
   logic [31:0] c;
   logic [31:0] v;
   logic [47:0] ent;
   logic [47:0] exp_q[$];

   imr_regs #(.TICK_CYCLES(TICK)) imr_regs_inst (
      .clk(clk), .reset(reset), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .meas(meas),
      .cond(cond), .cap_present(cap_present),
      .selftest_done(selftest_done), .selftest_fail(selftest_fail),
      .selftest_start(selftest_start), .selftest_busy(selftest_busy),
      .nv_uptime(nv_uptime), .nv_power_cycles(nv_power_cycles));

   imr_master imr_master_inst (.clk(clk), .req(reg_req));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // ==========================================================
   // checking
   task automatic check(input string what, input logic [31:0] e,
         input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic complete_run();
      if (failures == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic expect_word(input logic [15:0] a, input logic [15:0] e,
         input logic [15:0] m);
      exp_q.push_back({a, e, m});
   endtask

   task automatic rd16(input logic [15:0] a, input logic [15:0] e);
      expect_word(a, e, 16'hffff);
      imr_master_inst.read_words(a, 1);
   endtask

   task automatic rd32(input logic [15:0] a, input logic [31:0] e);
      expect_word(a, e[31:16], 16'hffff);
      expect_word(a + 16'h0001, e[15:0], 16'hffff);
      imr_master_inst.read_words(a, 2);
   endtask

   // each answer is matched to the oldest outstanding read
   always @(negedge clk) begin
      if (reg_rvalid === 1'b1) begin
         if (exp_q.size() == 0) begin
            check("unrequested read answer", 32'h0, 32'h1);
         end else begin
            ent = exp_q.pop_front();
            check($sformatf("word %h", ent[47:32]),
               {16'h0, ent[31:16] & ent[15:0]},
               {16'h0, reg_rdata & ent[15:0]});
         end
      end
   end

   function automatic logic [15:0] stat_exp(input imr_cond_type x,
         input logic f);
      logic [15:0] s;
      s = 16'h0000;
      s[STAT_BIT_STATUS] = x.alarm_active | x.prev_alarm_active |
         x.alarm_acked | x.first_meas;
      s[STAT_BIT_SYSERR] = x.inj_disconnected | x.over_voltage |
         x.over_capacitance;
      s[STAT_BIT_PRODERR] = f;
      s[STAT_BIT_INJOFF] = ~x.injection_active;
      return s;
   endfunction

   task automatic do_reset();
      @(posedge clk);
      reset <= 1'b1;
      repeat (3) @(posedge clk);
      @(negedge clk);
      check("outputs in reset", 32'h0, {reg_rdata, 13'h0, reg_rvalid,
         selftest_start, selftest_busy});
      @(posedge clk);
      reset <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      complete_run();
   end

   // ==========================================================
   // main sequence
   initial begin
      seed = $urandom(32'he42d);
      reset = 1'b1;
      meas = '0;
      cond = '0;
      cond.injection_active = 1'b1;
      cap_present = 1'b1;
      selftest_done = 1'b0;
      selftest_fail = 1'b0;
      nv_uptime = 64'h0123456789ab0000;
      nv_power_cycles = 32'h0000ffff;
      failures = 0;
      total_checks = 0;
      failed_exp = 1'b0;
      do_reset();
      expect_word(ADDR_UPTIME, 16'h0123, 16'hffff);
      expect_word(ADDR_UPTIME + 16'h0001, 16'h4567, 16'hffff);
      expect_word(ADDR_UPTIME + 16'h0002, 16'h89ab, 16'hffff);
      // lowest word advances with the tick, so it is not compared
      expect_word(ADDR_UPTIME + 16'h0003, 16'h0000, 16'h0000);
      imr_master_inst.read_words(ADDR_UPTIME, 4);
      rd32(ADDR_PCYC, 32'h00010000);
      rd16(16'h0100, 16'h0000);
      rd16(ADDR_TEST, 16'h0000);
      for (int i = 0; i < 5; i++) begin
         r = $urandom();
         c = $urandom();
         v = $urandom();
         meas.resistance <= r;
         meas.capacitance <= c;
         meas.ground_voltage <= v;
         meas.unit_status <= r ^ v;
         meas.res_qual <= imr_qual_type'(3'(i));
         meas.cap_qual <= imr_qual_type'(3'(4 - i));
         rd32(ADDR_RES, r);
         rd32(ADDR_CAP, c);
         rd16(ADDR_RQUAL, 16'(i));
         rd16(ADDR_CQUAL, 16'(4 - i));
         rd32(ADDR_VGND, v);
         rd32(ADDR_UNIT, r ^ v);
      end
      // halves must not tear when the value moves between them
      rd16(ADDR_RES, r[31:16]);
      meas.resistance <= ~r;
      rd16(ADDR_RES + 16'h0001, r[15:0]);
      r = ~r;
      for (int k = 0; k < 2; k++) begin
         cond.injection_active <= (k == 0);
         repeat (3) @(posedge clk);
         rd32(ADDR_INJ,
            (k == 0) ? INJ_ACTIVE_CODE : INJ_INACTIVE_CODE);
      end
      for (int k = 0; k < 12; k++) begin
         cv = (k < 5) ? imr_cond_type'((9'h100 >> k) | 9'h001) :
            imr_cond_type'(9'($urandom()));
         cond <= cv;
         repeat (3) @(posedge clk);
         rd16(ADDR_ALARM, {12'h000, cv.alarm_acked, cv.transient_alarm,
            cv.prev_alarm_active, cv.alarm_active});
         rd16(ADDR_STAT, stat_exp(cv, failed_exp));
         rd16(ADDR_STATN, ~stat_exp(cv, failed_exp));
      end
      imr_master_inst.write_word(ADDR_TEST, 16'h1234);
      @(negedge clk);
      check("start on wrong code", 32'h0, {31'h0, selftest_start});
      @(negedge clk);
      check("busy on wrong code", 32'h0, {31'h0, selftest_busy});
      for (int t = 0; t < 2; t++) begin
         imr_master_inst.write_word(ADDR_TEST, RUN_CODE);
         @(negedge clk);
         check("start and busy", 32'h3, {30'h0, selftest_start,
            selftest_busy});
         @(negedge clk);
         check("start pulse", 32'h0, {31'h0, selftest_start});
         rd32(ADDR_RES, NAN_PATTERN);
         rd32(ADDR_CAP, NAN_PATTERN);
         @(posedge clk);
         selftest_done <= 1'b1;
         selftest_fail <= (t == 0);
         @(posedge clk);
         selftest_done <= 1'b0;
         selftest_fail <= 1'b0;
         failed_exp = (t == 0);
         repeat (3) @(posedge clk);
         @(negedge clk);
         check("busy after done", 32'h0, {31'h0, selftest_busy});
         rd16(ADDR_STAT, stat_exp(cv, failed_exp));
         rd16(ADDR_STATN, ~stat_exp(cv, failed_exp));
      end
      rd32(ADDR_RES, r);
      cap_present <= 1'b0;
      repeat (2) @(posedge clk);
      rd32(ADDR_CAP, 32'h00000000);
      do_reset();
      rd32(ADDR_PCYC, 32'h00010000);
      // status counter restarts at reset and counts one change
      rd32(ADDR_SCNT, 32'h00000000);
      cond.injection_active <= ~cv.injection_active;
      repeat (3) @(posedge clk);
      rd32(ADDR_SCNT, 32'h00000001);
      repeat (5) @(posedge clk);
      check("reads left unanswered", 32'h0, 32'(exp_q.size()));
      complete_run();
   end
endmodule
